/* File: src/scm_pkg.sv */
// Shared constants, types and register map of the system clock controller
package scm_pkg;

  // Clock and oscillator rates
  localparam int unsigned HCLK_KHZ      = 125000;
  localparam int unsigned HCLK_MHZ      = 125;
  localparam int unsigned FAST_OSC_KHZ  = 30000;
  localparam int unsigned SLOW_OSC_KHZ  = 32;

  // Fast oscillator settle time, in microseconds, and in hclk cycles
  localparam int unsigned FAST_SETTLE_US  = 16;
  localparam int unsigned FAST_SETTLE_CYC = FAST_SETTLE_US * HCLK_MHZ;

  // Longest spacing of slow oscillator ticks, rounded up, plus one of jitter
  localparam int unsigned SLOW_GAP_MAX =
    (HCLK_KHZ + SLOW_OSC_KHZ - 1) / SLOW_OSC_KHZ + 1;

  // Register byte offsets
  localparam logic [7:0] OFS_SYSCLK_CTRL = 8'h00;
  localparam logic [7:0] OFS_FOSC_CTRL   = 8'h04;
  localparam logic [7:0] OFS_MODE_STAT   = 8'h08;

  // Field positions
  localparam int unsigned SEL_LSB        = 5;
  localparam int unsigned SEL_MSB        = 7;
  localparam int unsigned FAST_KEEP_BIT  = 1;
  localparam int unsigned SLOW_KEEP_BIT  = 0;
  localparam int unsigned FOSC_EN_BIT    = 0;
  localparam int unsigned FOSC_STBL_BIT  = 1;

  // Selection codes and reset values
  localparam logic [2:0] SEL_RESERVED = 3'h0;
  localparam logic [2:0] SEL_SUB      = 3'h7;
  localparam logic [2:0] SEL_RESET    = 3'h2;
  localparam logic       KEEP_RESET   = 1'h0;
  localparam logic       FOSC_EN_RST  = 1'h1;

  // Operating modes
  typedef enum logic [2:0] {
    MODE_FAST,
    MODE_SLOW,
    MODE_SLEEP,
    MODE_IDLE0,
    MODE_IDLE1,
    MODE_IDLE2
  } scm_mode_t;

  // Clock enable pulses handed to the rest of the chip
  typedef struct packed {
    logic sys;
    logic fast;
    logic sub;
    logic wdt;
    logic tbase;
  } scm_clk_en_t;

endpackage : scm_pkg

/* File: src/scm_rate_gen.sv */
// Fractional rate generator modelling one free RC oscillator as enable ticks
`timescale 1ns/10ps
`default_nettype none
module scm_rate_gen #(
  parameter int unsigned INC = 1,
  parameter int unsigned MOD = 2
) (
  input  wire logic hclk,
  input  wire logic hresetn,
  input  wire logic run,
  output logic      tick
);

  logic [16:0] acc;
  logic [17:0] sum;

  // Phase accumulator keeps the average rate exact
  assign sum = {1'b0, acc} + 18'(INC);

  // Stopped oscillator holds its phase and gives no ticks
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      acc  <= 17'h00000;
      tick <= 1'b0;
    end
    else if (run)
    begin
      if (sum >= 18'(MOD))
      begin
        acc  <= 17'(sum - 18'(MOD));
        tick <= 1'b1;
      end
      else
      begin
        acc  <= sum[16:0];
        tick <= 1'b0;
      end
    end
    else
    begin
      tick <= 1'b0;
    end
  end

endmodule : scm_rate_gen
`default_nettype wire

/* File: src/scm_top.sv */
// System clock selection and operating mode control with AHB-Lite registers
//
// Summary of operation
// - Internal fast RC source at 30MHz
// - Internal slow RC source near 32kHz
// - Select codes: /2../64, sub, 000 reserved
// - Sub clock comes from slow RC source
// - Slow RC source also clocks watchdog and time base
// - Fast oscillator on sub follows its enable
// - Fast mode: divided fast clock, all on
// - Halt with no keep bits: sleep
// - Slow RC source runs in every mode
// - Halt, only slow keep: idle0
// - Halt, both keep bits: idle1
// - Halt, only fast keep: idle2
// - Fast keep bit keeps fast oscillator running in halt
// - Slow keep bit keeps sub clock running in halt
// - Stable flag clears on enable, sets later
// - Unimplemented register bits read zero
// - Fast enable bit: 0 off, 1 on
//
// The AHB-Lite register port and the register addresses are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
module scm_top (
  input  wire logic                hclk,
  input  wire logic                hresetn,
  input  wire logic                hsel,
  input  wire logic [31:0]         haddr,
  input  wire logic [1:0]          htrans,
  input  wire logic                hwrite,
  input  wire logic [2:0]          hsize,
  input  wire logic [31:0]         hwdata,
  input  wire logic                hready,
  output logic      [31:0]         hrdata,
  output logic                     hreadyout,
  output logic                     hresp,
  input  wire logic                cpu_halt,
  output scm_pkg::scm_clk_en_t     clk_en,
  output scm_pkg::scm_mode_t       op_mode,
  output logic                     fast_osc_running
);
  import scm_pkg::*;

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  logic        ph_valid;
  logic        ph_write;
  logic [7:0]  ph_addr;
  logic        rd_wait;
  logic        wr_en;
  logic [2:0]  sysclk_select;
  logic        fast_osc_idle_keep;
  logic        slow_osc_idle_keep;
  logic        fast_osc_enable;
  logic        fast_osc_stable_flag;
  logic [2:0]  active_sel;
  logic        fast_run;
  logic        sub_run;
  logic        fast_tick;
  logic        low_speed_rc_osc_tick;
  logic [11:0] settle_cnt;
  logic        settle_done;
  logic        fosc_en_rise;
  logic [5:0]  fast_div_cnt;
  logic        sys_allowed;
  logic        sys_src_tick;
  logic        target_ready;
  scm_mode_t   next_mode;
  logic [12:0] low_speed_rc_osc_gap;

  // Tick needs all mask bits of the divider count set
  function automatic logic [5:0] div_mask(input logic [2:0] code);
    div_mask = 6'((7'h01 << code) - 7'h01);
  endfunction : div_mask

  // Bus address phase capture; reads add one wait state so hrdata is a flop
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ph_valid <= 1'b0;
      ph_write <= 1'b0;
      ph_addr  <= 8'h00;
    end
    else if (hready)
    begin
      ph_valid <= hsel && htrans[1];
      ph_write <= hwrite;
      ph_addr  <= haddr[7:0];
    end
  end

  // Read wait state lasts exactly one cycle
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      rd_wait <= 1'b0;
    else
      rd_wait <= ph_valid && !ph_write && !rd_wait;
  end

  // Handshake and response
  assign hreadyout = !(ph_valid && !ph_write && !rd_wait);
  assign hresp     = 1'b0;
  assign wr_en     = ph_valid && ph_write;

  // Read data, unmapped offsets and empty bits read zero
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata <= 32'h00000000;
    else if (ph_valid && !ph_write && !rd_wait)
    begin
      hrdata <= 32'h00000000;
      if (ph_addr == OFS_SYSCLK_CTRL)
      begin
        hrdata[SEL_MSB:SEL_LSB] <= sysclk_select;
        hrdata[FAST_KEEP_BIT]   <= fast_osc_idle_keep;
        hrdata[SLOW_KEEP_BIT]   <= slow_osc_idle_keep;
      end
      else if (ph_addr == OFS_FOSC_CTRL)
      begin
        hrdata[FOSC_STBL_BIT] <= fast_osc_stable_flag;
        hrdata[FOSC_EN_BIT]   <= fast_osc_enable;
      end
      else if (ph_addr == OFS_MODE_STAT)
        hrdata[7:0] <= {fast_run, active_sel, 1'b0, op_mode};
    end
  end

  // Control register writes
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      sysclk_select      <= SEL_RESET;
      fast_osc_idle_keep <= KEEP_RESET;
      slow_osc_idle_keep <= KEEP_RESET;
      fast_osc_enable    <= FOSC_EN_RST;
    end
    else if (wr_en && ph_addr == OFS_SYSCLK_CTRL)
    begin
      sysclk_select      <= hwdata[SEL_MSB:SEL_LSB];
      fast_osc_idle_keep <= hwdata[FAST_KEEP_BIT];
      slow_osc_idle_keep <= hwdata[SLOW_KEEP_BIT];
    end
    else if (wr_en && ph_addr == OFS_FOSC_CTRL)
      fast_osc_enable <= hwdata[FOSC_EN_BIT];
  end

  assign fosc_en_rise = wr_en && ph_addr == OFS_FOSC_CTRL
                        && hwdata[FOSC_EN_BIT] && !fast_osc_enable;

  // Oscillator run requests; outside halt fast also runs while it is or will be selected
  always_comb
  begin
    if (cpu_halt)
    begin
      fast_run = fast_osc_idle_keep;
      sub_run  = slow_osc_idle_keep;
    end
    else
    begin
      fast_run = fast_osc_enable || active_sel != SEL_SUB
                 || sysclk_select != SEL_SUB;
      sub_run  = 1'b1;
    end
  end

  assign fast_osc_running = fast_run;

  // Fast RC source at its nominal rate
  scm_rate_gen #(
    .INC (FAST_OSC_KHZ),
    .MOD (HCLK_KHZ)
  ) u_fast_osc (
    .hclk    (hclk),
    .hresetn (hresetn),
    .run     (fast_run),
    .tick    (fast_tick)
  );

  // Slow RC source never stops, the watchdog depends on it
  scm_rate_gen #(
    .INC (SLOW_OSC_KHZ),
    .MOD (HCLK_KHZ)
  ) u_slow_osc (
    .hclk    (hclk),
    .hresetn (hresetn),
    .run     (1'b1),
    .tick    (low_speed_rc_osc_tick)
  );

  // Settle timer; the enable write clears the flag even at the settle edge
  assign settle_done = settle_cnt == 12'(FAST_SETTLE_CYC - 1);

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      settle_cnt           <= 12'h000;
      fast_osc_stable_flag <= 1'b0;
    end
    else if (!fast_run || fosc_en_rise)
    begin
      settle_cnt           <= 12'h000;
      fast_osc_stable_flag <= 1'b0;
    end
    else if (settle_done)
      fast_osc_stable_flag <= 1'b1;
    else if (!fast_osc_stable_flag)
      settle_cnt <= settle_cnt + 12'h001;
  end

  // Divider chain off the fast source
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      fast_div_cnt <= 6'h00;
    else if (fast_tick)
      fast_div_cnt <= fast_div_cnt + 6'h01;
  end

  // Source tick of the active selection; fast ticks wait for stability
  always_comb
  begin
    if (active_sel == SEL_SUB)
      sys_src_tick = low_speed_rc_osc_tick && sub_run;
    else
      sys_src_tick = fast_tick && fast_osc_stable_flag
                     && (fast_div_cnt & div_mask(active_sel))
                        == div_mask(active_sel);
  end

  // Switch only between pulses and only to a running, stable source
  assign target_ready = sysclk_select == SEL_SUB || fast_osc_stable_flag;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      active_sel <= SEL_RESET;
    else if (sysclk_select != active_sel && sysclk_select != SEL_RESERVED
             && target_ready && !sys_src_tick)
      active_sel <= sysclk_select;
  end

  // Mode from halt and keep bits
  always_comb
  begin
    if (!cpu_halt)
      next_mode = (active_sel == SEL_SUB) ? MODE_SLOW : MODE_FAST;
    else
    begin
      case ({fast_osc_idle_keep, slow_osc_idle_keep})
        2'b00:   next_mode = MODE_SLEEP;
        2'b01:   next_mode = MODE_IDLE0;
        2'b11:   next_mode = MODE_IDLE1;
        default: next_mode = MODE_IDLE2;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      op_mode <= MODE_FAST;
    else
      op_mode <= next_mode;
  end

  // System clock permission per mode
  always_comb
  begin
    case (op_mode)
      MODE_SLEEP: sys_allowed = 1'b0;
      MODE_IDLE0: sys_allowed = active_sel == SEL_SUB;
      MODE_IDLE2: sys_allowed = active_sel != SEL_SUB;
      default:    sys_allowed = 1'b1;
    endcase
  end

  // Registered enable pulses for consumers
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      clk_en <= '0;
    else
    begin
      clk_en.sys   <= sys_src_tick && sys_allowed;
      clk_en.fast  <= fast_tick;
      clk_en.sub   <= low_speed_rc_osc_tick && sub_run;
      clk_en.wdt   <= low_speed_rc_osc_tick;
      clk_en.tbase <= low_speed_rc_osc_tick && sub_run;
    end
  end

  // Helper: spacing of slow ticks
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      low_speed_rc_osc_gap <= 13'h0000;
    else if (clk_en.wdt)
      low_speed_rc_osc_gap <= 13'h0000;
    else
      low_speed_rc_osc_gap <= low_speed_rc_osc_gap + 13'h0001;
  end

  sequence s_halt_no_fast;
    (cpu_halt && !fast_osc_idle_keep) [*2];
  endsequence

  chk_low_speed_rc_osc_never_stops: assert property (low_speed_rc_osc_gap <= 13'(SLOW_GAP_MAX))
    else $error("slow oscillator tick missing");
  chk_sleep_sys_off: assert property (op_mode == MODE_SLEEP |=> !clk_en.sys)
    else $error("system clock ran in sleep");
  // Mode register lags the halt input by one cycle, so gate on the halt itself too
  chk_idle2_sub_off: assert property (op_mode == MODE_IDLE2 && cpu_halt |=> !clk_en.sub)
    else $error("sub clock ran in idle2");
  chk_halt_fast_stop: assert property (s_halt_no_fast |=> !clk_en.fast)
    else $error("fast clock ran while halted without keep");
  chk_enable_clears_flag: assert property (fosc_en_rise |=> !fast_osc_stable_flag)
    else $error("stable flag not cleared on enable");
  chk_switch_legal_code: assert property ($changed(active_sel) |->
      active_sel == $past(sysclk_select) && active_sel != SEL_RESERVED)
    else $error("illegal clock selection taken");
  chk_switch_waits_stable: assert property ($changed(active_sel)
      && active_sel != SEL_SUB |-> $past(fast_osc_stable_flag))
    else $error("switched to unstable fast clock");
  chk_idle0_gate_fast: assert property (op_mode == MODE_IDLE0
      && active_sel != SEL_SUB |=> !clk_en.sys)
    else $error("divided fast system clock in idle0");
  chk_sub_from_low_speed_rc_osc: assert property (clk_en.sub |-> clk_en.wdt)
    else $error("sub clock not from slow source");
  chk_enable_runs_fast: assert property (!cpu_halt && fast_osc_enable |-> fast_run)
    else $error("fast oscillator off while enabled");
  chk_idle1_both_run: assert property (op_mode == MODE_IDLE1 |-> fast_run && sub_run)
    else $error("clock stopped in idle1");

endmodule : scm_top
`default_nettype wire

/* File: dv/scm_top_test.sv */
// Self-checking bench for the system clock and mode controller
`timescale 1ns/10ps
`default_nettype none
module scm_top_test;
  import scm_pkg::*;
  logic        hclk     = 1'b0;
  logic        hresetn  = 1'b0;
  logic        hsel     = 1'b0;
  logic [31:0] haddr    = 32'h0;
  logic [1:0]  htrans   = 2'h0;
  logic        hwrite   = 1'b0;
  logic [2:0]  hsize    = 3'h2;
  logic [31:0] hwdata   = 32'h0;
  logic        cpu_halt = 1'b0;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  scm_clk_en_t clk_en;
  scm_mode_t   op_mode;
  logic        fast_osc_running;
  int          error_cnt = 0;
  int          n_checks  = 0;
  int          cnt [5];
  logic [31:0] rd;
  logic [2:0]  sel;
  logic        sys_exp;
  scm_mode_t   hmode [4] = '{MODE_SLEEP, MODE_IDLE0, MODE_IDLE2, MODE_IDLE1};

  // Bus clock, 8 ns period
  always #4 hclk = ~hclk;

  scm_top dut (
    .hclk             (hclk),
    .hresetn          (hresetn),
    .hsel             (hsel),
    .haddr            (haddr),
    .htrans           (htrans),
    .hwrite           (hwrite),
    .hsize            (hsize),
    .hwdata           (hwdata),
    .hready           (hreadyout),
    .hrdata           (hrdata),
    .hreadyout        (hreadyout),
    .hresp            (hresp),
    .cpu_halt         (cpu_halt),
    .clk_en           (clk_en),
    .op_mode          (op_mode),
    .fast_osc_running (fast_osc_running)
  );

  // Mismatch report shared by every compare
  task automatic fail(input logic [31:0] got, input logic [31:0] exp);
    error_cnt++;
    $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
  endtask : fail

  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) fail(got, exp);
  endtask : chk32

  task automatic chk_mode(input scm_mode_t exp);
    n_checks++;
    if (op_mode !== exp) fail(32'(op_mode), 32'(exp));
  endtask : chk_mode

  // Activity only: pulse counts vary with oscillator phase
  task automatic chk_act(input int n, input logic exp);
    n_checks++;
    if ((n > 0) !== exp) fail(32'(n), {31'h0, exp});
  endtask : chk_act

  // Single AHB-Lite transfer; entered just after a rising edge
  task automatic bus_xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr  <= {24'h0, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wr ? d : 32'h0;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : bus_xfer

  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
    bus_xfer(1'b1, a, d);
  endtask : bus_wr

  task automatic bus_rd(input logic [7:0] a);
    bus_xfer(1'b0, a, 32'h0);
  endtask : bus_rd

  // Count enable pulses over a window of n cycles
  task automatic watch(input int n);
    cnt = '{default: 0};
    repeat (n)
    begin
      @(posedge hclk);
      cnt[0] += int'(clk_en.sys);
      cnt[1] += int'(clk_en.fast);
      cnt[2] += int'(clk_en.sub);
      cnt[3] += int'(clk_en.wdt);
      cnt[4] += int'(clk_en.tbase);
    end
  endtask : watch

  // Software poll of the stable flag, as firmware would do
  task automatic wait_stable;
    do bus_rd(OFS_FOSC_CTRL); while (rd[FOSC_STBL_BIT] !== 1'b1);
  endtask : wait_stable

  task automatic results;
    $display("checks=%0d mismatches=%0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : results

  // Hang guard, above the roughly 85k cycles of the tests
  initial
  begin
    repeat (99000) @(posedge hclk);
    error_cnt++;
    results();
  end

  // Main sequence
  initial
  begin
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    bus_rd(OFS_SYSCLK_CTRL);
    chk32(rd, 32'h40);
    bus_rd(OFS_FOSC_CTRL);
    chk32(rd, 32'h01);
    bus_rd(8'h0C);
    chk32(rd, 32'h0);
    chk32({31'h0, hresp}, 32'h0);
    chk_mode(MODE_FAST);
    watch(100);
    chk_act(cnt[0], 1'b0);
    wait_stable();
    chk32(rd, 32'h03);
    $display("test reset done");
    // Reserved code stored but ignored; unused bits dropped
    bus_wr(OFS_SYSCLK_CTRL, 32'hFFFF_FF1C);
    bus_rd(OFS_SYSCLK_CTRL);
    chk32(rd, 32'h00);
    bus_wr(OFS_FOSC_CTRL, 32'hFFFF_FFFF);
    bus_rd(OFS_FOSC_CTRL);
    chk32(rd, 32'h03);
    watch(200);
    chk_mode(MODE_FAST);
    chk_act(cnt[0], 1'b1);
    $display("test registers done");
    // Every keep-bit pair under a fast and the sub selection
    for (int s = 0; s < 2; s++)
    begin
      for (int k = 0; k < 4; k++)
      begin
        sel = (s == 1) ? SEL_SUB : 3'h1;
        sys_exp = (k == 3) || (k == 1 && s == 1) || (k == 2 && s == 0);
        bus_wr(OFS_SYSCLK_CTRL, {24'h0, sel, 3'h0, 2'(k)});
        if (k == 0) watch(4000);
        watch(4000);
        chk_mode((s == 1) ? MODE_SLOW : MODE_FAST);
        for (int b = 0; b < 5; b++) chk_act(cnt[b], 1'b1);
        cpu_halt <= 1'b1;
        repeat (3) @(posedge hclk);
        chk_mode(hmode[k]);
        watch(4000);
        chk_act(cnt[0], sys_exp);
        chk_act(cnt[1], k[1]);
        chk_act(cnt[2], k[0]);
        chk_act(cnt[3], 1'b1);
        chk_act(cnt[4], k[0]);
        cpu_halt <= 1'b0;
        @(posedge hclk);
      end
    end
    $display("test modes done");
    // Fast oscillator off while on the sub clock, then back to fast
    bus_wr(OFS_SYSCLK_CTRL, 32'hE0);
    bus_wr(OFS_FOSC_CTRL, 32'h0);
    // Let the last fast ticks drain; slow ticks are ~3906 cycles apart
    repeat (3) @(posedge hclk);
    watch(4000);
    chk32({31'h0, fast_osc_running}, 32'h0);
    chk_act(cnt[1], 1'b0);
    chk_act(cnt[0], 1'b1);
    bus_rd(OFS_FOSC_CTRL);
    chk32(rd, 32'h00);
    bus_wr(OFS_FOSC_CTRL, 32'h1);
    bus_rd(OFS_FOSC_CTRL);
    chk32(rd, 32'h01);
    wait_stable();
    chk32(rd, 32'h03);
    bus_wr(OFS_SYSCLK_CTRL, 32'h20);
    watch(4000);
    chk_mode(MODE_FAST);
    chk_act(cnt[0], 1'b1);
    bus_rd(OFS_MODE_STAT);
    chk32(rd, 32'h90);
    $display("test oscillator enable done");
    results();
  end
endmodule : scm_top_test
`default_nettype wire
